// ===== gp_timer_cfg.svh
`ifndef GP_TIMER_CFG_SVH
`define GP_TIMER_CFG_SVH
// ==========================================
// register byte offsets
`define OFS_CTL0 8'h00
`define OFS_CNT0 8'h04
`define OFS_CMP0 8'h08
`define OFS_PER0 8'h0C
`define OFS_CTL1 8'h10
`define OFS_CNT1 8'h14
`define OFS_CMP1 8'h18
`define OFS_PER1 8'h1C
`define OFS_SHARED 8'h20
`define OFS_FLAGS 8'h24
`define OFS_MASK 8'h28
// ==========================================
// register indices
`define IDX_CTL 2'h0
`define IDX_CNT 2'h1
`define IDX_CMP 2'h2
`define IDX_PER 2'h3
`define IDX_SHARED 4'h8
`define IDX_FLAGS 4'h9
`define IDX_MASK 4'hA
`define IDX_NONE 4'hF
// ==========================================
// timer control fields
`define CTL_MASTER_PER 0
`define CTL_CMP_EN 1
`define CTL_RELOAD_LO 2
`define CTL_RELOAD_HI 3
`define CTL_SRC_LO 4
`define CTL_SRC_HI 5
`define CTL_RUN 6
`define CTL_SWM 7
`define CTL_PS_LO 8
`define CTL_PS_HI 10
`define CTL_MODE_LO 11
`define CTL_MODE_HI 12
`define CTL_EMU_LO 14
`define CTL_EMU_HI 15
// ==========================================
// shared control and flag fields
`define SH_DIR0 13
`define SH_DIR1 14
`define FLG_OVF 0
`define FLG_UDF 1
`define FLG_CMP 2
`define FLG_PER 3
// ==========================================
// values
`define RST_16 16'h0000
`define CNT_TOP 16'hFFFF
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// ===== gp_timer_far_side.sv
module gp_timer_far_side (
	input wire logic aclk,
	input wire logic aresetn,
	output logic external_tick_pin,
	output logic quad_tick,
	output logic quad_dir
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [2:0] div_r;
	// ==========================================
	// divider shared by the pin and the decoder
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			div_r <= 3'h0;
		else
			div_r <= div_r + 3'h1;
	end
	// pin: square wave at one eighth of the device clock
	assign external_tick_pin = div_r[2];
	// decoder: one-cycle tick every fourth cycle, counting up
	assign quad_tick = (div_r[1:0] == 2'h3);
	assign quad_dir = 1'b1;
endmodule // gp_timer_far_side

// ===== gp_timer_pair_counter.sv
`include "gp_timer_cfg.svh"
module gp_timer_pair_counter (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire logic direction_pin,
	input wire logic external_tick_pin,
	input wire logic quad_tick,
	input wire logic quad_dir,
	input wire logic emu_suspend,
	output logic adc_start_master,
	output logic adc_start_slave,
	output logic irq_master,
	output logic irq_slave
);
	// ==========================================
	// helpers
	function automatic logic [3:0] reg_index(input logic [7:0] a);
		if (a == `OFS_CTL0) reg_index = {2'h0, `IDX_CTL};
		else if (a == `OFS_CNT0) reg_index = {2'h0, `IDX_CNT};
		else if (a == `OFS_CMP0) reg_index = {2'h0, `IDX_CMP};
		else if (a == `OFS_PER0) reg_index = {2'h0, `IDX_PER};
		else if (a == `OFS_CTL1) reg_index = {2'h1, `IDX_CTL};
		else if (a == `OFS_CNT1) reg_index = {2'h1, `IDX_CNT};
		else if (a == `OFS_CMP1) reg_index = {2'h1, `IDX_CMP};
		else if (a == `OFS_PER1) reg_index = {2'h1, `IDX_PER};
		else if (a == `OFS_SHARED) reg_index = `IDX_SHARED;
		else if (a == `OFS_FLAGS) reg_index = `IDX_FLAGS;
		else if (a == `OFS_MASK) reg_index = `IDX_MASK;
		else reg_index = `IDX_NONE;
	endfunction

	function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s);
		merge = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
	endfunction

	function automatic logic [6:0] ps_limit(input logic [2:0] ps);
		ps_limit = 7'((8'h01 << ps) - 8'h01);
	endfunction

	// next {up/down direction, count} for one tick
	function automatic logic [16:0] step(input gp_timer_pkg::mode_t m, input logic [15:0] c,
		input logic [15:0] p, input logic dl, input logic ud);
		step = {ud, c};
		case (m)
			gp_timer_pkg::mode_up:
				step = {ud, (c == p) ? 16'h0000 : c + 16'h0001};
			gp_timer_pkg::mode_dir:
				if (dl)
					step = {ud, (c == p) ? 16'h0000 : c + 16'h0001};
				else
					step = {ud, (c == 16'h0000) ? p : c - 16'h0001};
			gp_timer_pkg::mode_updown:
				if (ud)
				begin
					if (c == `CNT_TOP) step = {1'b1, 16'h0000};
					else if (c == p) step = {1'b0, (c == 16'h0000) ? c : c - 16'h0001};
					else step = {1'b1, c + 16'h0001};
				end
				else
				begin
					if (c == 16'h0000) step = {1'b1, (p == 16'h0000) ? c : c + 16'h0001};
					else step = {1'b0, c - 16'h0001};
				end
			default:
				step = {ud, c};
		endcase
	endfunction

	// ==========================================
	// bus slave
	logic aw_hold_r, w_hold_r, bvalid_r, rvalid_r;
	logic [7:0] awaddr_r;
	logic [31:0] wdata_r, rdata_r;
	logic [3:0] wstrb_r, wr_idx;
	logic [1:0] bresp_r, rresp_r;
	logic wr_fire;
	logic [15:0] rd_val;
	logic [3:0] rd_idx;

	assign awready = !aw_hold_r;
	assign wready = !w_hold_r;
	assign bvalid = bvalid_r;
	assign bresp = bresp_r;
	assign arready = !rvalid_r;
	assign rvalid = rvalid_r;
	assign rdata = rdata_r;
	assign rresp = rresp_r;
	assign wr_fire = aw_hold_r && w_hold_r && !bvalid_r;
	assign wr_idx = reg_index(awaddr_r);
	assign rd_idx = reg_index(araddr);

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_hold_r <= 1'b0;
			awaddr_r <= 8'h00;
		end
		else if (awvalid && !aw_hold_r)
		begin
			aw_hold_r <= 1'b1;
			awaddr_r <= awaddr;
		end
		else if (wr_fire)
			aw_hold_r <= 1'b0;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			w_hold_r <= 1'b0;
			wdata_r <= 32'h00000000;
			wstrb_r <= 4'h0;
		end
		else if (wvalid && !w_hold_r)
		begin
			w_hold_r <= 1'b1;
			wdata_r <= wdata;
			wstrb_r <= wstrb;
		end
		else if (wr_fire)
			w_hold_r <= 1'b0;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			bvalid_r <= 1'b0;
			bresp_r <= `RESP_OKAY;
		end
		else if (wr_fire)
		begin
			bvalid_r <= 1'b1;
			bresp_r <= (wr_idx == `IDX_NONE) ? `RESP_SLVERR : `RESP_OKAY;
		end
		else if (bready)
			bvalid_r <= 1'b0;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rvalid_r <= 1'b0;
			rdata_r <= 32'h00000000;
			rresp_r <= `RESP_OKAY;
		end
		else if (arvalid && !rvalid_r)
		begin
			rvalid_r <= 1'b1;
			rdata_r <= {16'h0000, rd_val};
			rresp_r <= (rd_idx == `IDX_NONE) ? `RESP_SLVERR : `RESP_OKAY;
		end
		else if (rready)
			rvalid_r <= 1'b0;
	end

	// ==========================================
	// registers
	logic [15:0] ctl_r [0:1];
	logic [15:0] cnt_r [0:1];
	logic [15:0] cmp_sh_r [0:1];
	logic [15:0] cmp_act_r [0:1];
	logic [15:0] per_sh_r [0:1];
	logic [15:0] per_act_r [0:1];
	logic [3:0] soc_sel_r;
	logic [7:0] flag_r, mask_r, flag_set;
	logic [1:0] dir_stat;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			for (int t = 0; t < 2; t++)
			begin
				ctl_r[t] <= `RST_16;
				cmp_sh_r[t] <= `RST_16;
				per_sh_r[t] <= `RST_16;
			end
			soc_sel_r <= 4'h0;
			mask_r <= 8'h00;
		end
		else if (wr_fire)
		begin
			for (int t = 0; t < 2; t++)
			begin
				if (wr_idx == {2'(t), `IDX_CTL}) ctl_r[t] <= merge(ctl_r[t], wdata_r, wstrb_r);
				if (wr_idx == {2'(t), `IDX_CMP}) cmp_sh_r[t] <= merge(cmp_sh_r[t], wdata_r, wstrb_r);
				if (wr_idx == {2'(t), `IDX_PER}) per_sh_r[t] <= merge(per_sh_r[t], wdata_r, wstrb_r);
			end
			if (wr_idx == `IDX_SHARED && wstrb_r[0]) soc_sel_r <= wdata_r[3:0];
			if (wr_idx == `IDX_MASK && wstrb_r[0]) mask_r <= wdata_r[7:0];
		end
	end

	always_comb
	begin
		rd_val = 16'h0000;
		if (rd_idx == `IDX_SHARED) rd_val = {1'b0, dir_stat[1], dir_stat[0], 9'h000, soc_sel_r};
		else if (rd_idx == `IDX_FLAGS) rd_val = {8'h00, flag_r};
		else if (rd_idx == `IDX_MASK) rd_val = {8'h00, mask_r};
		else if (rd_idx != `IDX_NONE)
		begin
			case (rd_idx[1:0])
				`IDX_CTL: rd_val = ctl_r[rd_idx[2]];
				`IDX_CNT: rd_val = cnt_r[rd_idx[2]];
				`IDX_CMP: rd_val = cmp_sh_r[rd_idx[2]];
				default: rd_val = per_sh_r[rd_idx[2]];
			endcase
		end
	end

	// ==========================================
	// tick generation
	gp_timer_pkg::mode_t mode [0:1];
	gp_timer_pkg::clk_src_t src [0:1];
	gp_timer_pkg::emu_t emu [0:1];
	logic [1:0] run_eff, go, base, tick, quad_sel, halt, start, cnt_wr, dir_in, cmp_en;
	logic [1:0] run_q_r, arrive_r, dl_r, ud_r, ext_q_r, ext_edge, soc_r;
	logic [6:0] ps_cnt_r [0:1];
	logic [15:0] per_use [0:1];
	logic [16:0] nxt [0:1];
	logic [3:0] ev [0:1];

	assign run_eff[0] = ctl_r[0][`CTL_RUN];
	assign run_eff[1] = ctl_r[1][`CTL_RUN] || (ctl_r[1][`CTL_SWM] && ctl_r[0][`CTL_RUN]);
	assign per_use[0] = per_act_r[0];
	assign per_use[1] = ctl_r[1][`CTL_MASTER_PER] ? per_act_r[0] : per_act_r[1];

	always_comb
	begin
		for (int t = 0; t < 2; t++)
		begin
			mode[t] = gp_timer_pkg::mode_t'(ctl_r[t][`CTL_MODE_HI:`CTL_MODE_LO]);
			src[t] = gp_timer_pkg::clk_src_t'(ctl_r[t][`CTL_SRC_HI:`CTL_SRC_LO]);
			emu[t] = gp_timer_pkg::emu_t'(ctl_r[t][`CTL_EMU_HI:`CTL_EMU_LO]);
			cmp_en[t] = ctl_r[t][`CTL_CMP_EN];
			ext_edge[t] = external_tick_pin && !ext_q_r[t];
			quad_sel[t] = (t == 1) && src[t] == gp_timer_pkg::src_quad && mode[t] == gp_timer_pkg::mode_dir;
			halt[t] = emu_suspend && (emu[t] == gp_timer_pkg::emu_halt_now
				|| (emu[t] == gp_timer_pkg::emu_halt_end && cnt_r[t] == 16'h0000));
			go[t] = run_eff[t] && mode[t] != gp_timer_pkg::mode_stop && !halt[t];
			if (quad_sel[t]) base[t] = quad_tick;
			else if (src[t] == gp_timer_pkg::src_ext) base[t] = ext_edge[t];
			else base[t] = 1'b1;
			tick[t] = go[t] && base[t] && (quad_sel[t] || ps_cnt_r[t] == ps_limit(ctl_r[t][`CTL_PS_HI:`CTL_PS_LO]));
			dir_in[t] = quad_sel[t] ? quad_dir : direction_pin;
			start[t] = run_eff[t] && !run_q_r[t];
			cnt_wr[t] = wr_fire && wr_idx == {2'(t), `IDX_CNT};
			nxt[t] = step(mode[t], cnt_r[t], per_use[t], dl_r[t], ud_r[t]);
			if (mode[t] == gp_timer_pkg::mode_up) dir_stat[t] = 1'b1;
			else if (mode[t] == gp_timer_pkg::mode_dir) dir_stat[t] = dl_r[t];
			else dir_stat[t] = ud_r[t];
			ev[t][`FLG_OVF] = arrive_r[t] && cnt_r[t] == `CNT_TOP;
			ev[t][`FLG_UDF] = arrive_r[t] && cnt_r[t] == 16'h0000;
			ev[t][`FLG_CMP] = arrive_r[t] && cmp_en[t] && cnt_r[t] == cmp_act_r[t];
			ev[t][`FLG_PER] = arrive_r[t] && cnt_r[t] == per_use[t];
		end
	end

	always_ff @(posedge aclk)
	begin
		for (int t = 0; t < 2; t++)
		begin
			if (!aresetn)
				ps_cnt_r[t] <= 7'h00;
			else if (!run_eff[t])
				ps_cnt_r[t] <= 7'h00;
			else if (go[t] && base[t] && !quad_sel[t])
				ps_cnt_r[t] <= tick[t] ? 7'h00 : ps_cnt_r[t] + 7'h01;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ext_q_r <= 2'h0;
			run_q_r <= 2'h0;
			arrive_r <= 2'h0;
		end
		else
		begin
			ext_q_r <= {2{external_tick_pin}};
			run_q_r <= run_eff;
			arrive_r <= tick | start;
		end
	end

	// ==========================================
	// counters and direction
	always_ff @(posedge aclk)
	begin
		for (int t = 0; t < 2; t++)
		begin
			if (!aresetn)
			begin
				cnt_r[t] <= `RST_16;
				ud_r[t] <= 1'b1;
				dl_r[t] <= 1'b1;
			end
			else
			begin
				if (cnt_wr[t])
					cnt_r[t] <= merge(cnt_r[t], wdata_r, wstrb_r);
				else if (tick[t])
					cnt_r[t] <= nxt[t][15:0];
				if (tick[t])
				begin
					ud_r[t] <= nxt[t][16];
					dl_r[t] <= dir_in[t];
				end
			end
		end
	end

	// ==========================================
	// period and compare reload
	always_ff @(posedge aclk)
	begin
		for (int t = 0; t < 2; t++)
		begin
			if (!aresetn)
			begin
				per_act_r[t] <= `RST_16;
				cmp_act_r[t] <= `RST_16;
			end
			else
			begin
				if (cnt_r[t] == 16'h0000)
					per_act_r[t] <= per_sh_r[t];
				case (gp_timer_pkg::reload_t'(ctl_r[t][`CTL_RELOAD_HI:`CTL_RELOAD_LO]))
					gp_timer_pkg::rl_zero:
						if (!cmp_en[t] || cnt_r[t] == 16'h0000) cmp_act_r[t] <= cmp_sh_r[t];
					gp_timer_pkg::rl_zero_per:
						if (!cmp_en[t] || cnt_r[t] == 16'h0000 || cnt_r[t] == per_use[t])
							cmp_act_r[t] <= cmp_sh_r[t];
					default:
						cmp_act_r[t] <= cmp_sh_r[t];
				endcase
			end
		end
	end

	// ==========================================
	// flags, interrupt requests and converter start
	always_comb
	begin
		flag_set = {ev[1], ev[0]};
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			flag_r <= 8'h00;
		else if (wr_fire && wr_idx == `IDX_FLAGS && wstrb_r[0])
			flag_r <= (flag_r & ~wdata_r[7:0]) | flag_set;
		else
			flag_r <= flag_r | flag_set;
	end

	assign irq_master = |(flag_r[3:0] & mask_r[3:0]);
	assign irq_slave = |(flag_r[7:4] & mask_r[7:4]);

	always_ff @(posedge aclk)
	begin
		for (int t = 0; t < 2; t++)
		begin
			if (!aresetn)
				soc_r[t] <= 1'b0;
			else
			begin
				case (gp_timer_pkg::soc_t'(soc_sel_r[2 * t +: 2]))
					gp_timer_pkg::soc_udf: soc_r[t] <= ev[t][`FLG_UDF];
					gp_timer_pkg::soc_per: soc_r[t] <= ev[t][`FLG_PER];
					gp_timer_pkg::soc_cmp: soc_r[t] <= ev[t][`FLG_CMP];
					default: soc_r[t] <= 1'b0;
				endcase
			end
		end
	end

	assign adc_start_master = soc_r[0];
	assign adc_start_slave = soc_r[1];

	// ==========================================
	// checks
	a_sync_start:
	assert property (@(posedge aclk) disable iff (!aresetn)
		$rose(ctl_r[0][`CTL_RUN]) && ctl_r[1][`CTL_SWM] |-> run_eff[1] && start[0] == start[1] || run_q_r[1])
	else $error("slave did not start with master");
	a_slave_period:
	assert property (@(posedge aclk) disable iff (!aresetn)
		tick[1] && !cnt_wr[1] && ctl_r[1][`CTL_MASTER_PER] && mode[1] == gp_timer_pkg::mode_up
		&& cnt_r[1] == per_act_r[0] |=> cnt_r[1] == 16'h0000)
	else $error("slave ignored master period");
	a_hold_still:
	assert property (@(posedge aclk) disable iff (!aresetn)
		!go[0] && !cnt_wr[0] |=> $stable(cnt_r[0]))
	else $error("counter moved while held");
	a_emu_halt:
	assert property (@(posedge aclk) disable iff (!aresetn)
		emu_suspend && emu[0] == gp_timer_pkg::emu_halt_now && !cnt_wr[0] |=> $stable(cnt_r[0]))
	else $error("counter moved in suspend");
	a_prescale_clear:
	assert property (@(posedge aclk) disable iff (!aresetn)
		!run_eff[0] |=> ps_cnt_r[0] == 7'h00)
	else $error("prescaler not cleared");
	a_up_wrap:
	assert property (@(posedge aclk) disable iff (!aresetn)
		tick[0] && !cnt_wr[0] && mode[0] == gp_timer_pkg::mode_up && cnt_r[0] == per_use[0]
		|=> cnt_r[0] == 16'h0000 && ev[0][`FLG_UDF] ##1 flag_r[`FLG_UDF])
	else $error("up count did not wrap");
	a_period_flag:
	assert property (@(posedge aclk) disable iff (!aresetn)
		tick[0] && !cnt_wr[0] && nxt[0][15:0] == per_use[0] && cnt_r[0] == 16'h0000
		&& per_sh_r[0] == per_act_r[0] |=> ##1 flag_r[`FLG_PER])
	else $error("period flag late");
	a_cmp_flag:
	assert property (@(posedge aclk) disable iff (!aresetn)
		arrive_r[0] && cmp_en[0] && cnt_r[0] == cmp_act_r[0] |=> flag_r[`FLG_CMP])
	else $error("compare flag missing");
	a_ovf_flag:
	assert property (@(posedge aclk) disable iff (!aresetn)
		arrive_r[0] && cnt_r[0] == `CNT_TOP |=> flag_r[`FLG_OVF])
	else $error("overflow flag missing");
	a_soc_period:
	assert property (@(posedge aclk) disable iff (!aresetn)
		ev[0][`FLG_PER] && soc_sel_r[1:0] == 2'h2 |=> adc_start_master && flag_r[`FLG_PER])
	else $error("converter start not with flag");
	a_period_load:
	assert property (@(posedge aclk) disable iff (!aresetn)
		cnt_r[0] != 16'h0000 |=> per_act_r[0] == $past(per_act_r[0]))
	else $error("period loaded off zero");
	a_up_dir:
	assert property (@(posedge aclk) disable iff (!aresetn)
		mode[0] == gp_timer_pkg::mode_up |-> dir_stat[0])
	else $error("up mode direction not one");
endmodule // gp_timer_pair_counter

// ===== gp_timer_pair_counter_tb.sv
`include "gp_timer_cfg.svh"
module gp_timer_pair_counter_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready, direction_pin, external_tick_pin;
	logic quad_tick, quad_dir, emu_suspend, adc_start_master, adc_start_slave, irq_master, irq_slave;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, rsp;
	int n_errors = 0;
	int checks_done = 0;
	// ==========================================
	// design and far side
	gp_timer_pair_counter gp_timer_pair_counter_inst (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
		.awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .direction_pin(direction_pin),
		.external_tick_pin(external_tick_pin), .quad_tick(quad_tick), .quad_dir(quad_dir),
		.emu_suspend(emu_suspend), .adc_start_master(adc_start_master), .adc_start_slave(adc_start_slave),
		.irq_master(irq_master), .irq_slave(irq_slave));
	gp_timer_far_side gp_timer_far_side_inst (.aclk(aclk), .aresetn(aresetn),
		.external_tick_pin(external_tick_pin), .quad_tick(quad_tick), .quad_dir(quad_dir));
	// ==========================================
	// clock and watchdog
	initial
	begin
		aclk = 1'b0;
		forever #25 aclk = ~aclk;
	end
	initial
	begin
		#2000000;
		n_errors++;
		tally_and_finish();
	end
	// ==========================================
	// checking and bus tasks
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			$display("ERROR %0t: seen %h expected %h", $time, seen, exp);
			n_errors++;
		end
	endtask
	task automatic tally_and_finish();
		$display("checks %0d errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic aw;
		logic w;
		@(posedge aclk);
		aw = 1'b1;
		w = 1'b1;
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= d;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (aw || w)
		begin
			@(posedge aclk);
			if (aw && awready === 1'b1)
			begin
				aw = 1'b0;
				awvalid <= 1'b0;
			end
			if (w && wready === 1'b1)
			begin
				w = 1'b0;
				wvalid <= 1'b0;
			end
		end
		while (bvalid !== 1'b1)
			@(posedge aclk);
		rsp = bresp;
		bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge aclk); while (rvalid !== 1'b1);
		d = rdata;
		rsp = rresp;
		rready <= 1'b0;
	endtask
	// cycles between two successive converter start pulses
	task automatic gap(input logic s, input logic [31:0] e);
		longint t0;
		t0 = -1;
		forever
		begin
			@(posedge aclk);
			if ((s ? adc_start_slave : adc_start_master) === 1'b1)
			begin
				if (t0 >= 0)
					break;
				t0 = $time;
			end
		end
		chk(32'(($time - t0) / 50), e);
	endtask
	// master count read twice must be equal
	task automatic frozen();
		logic [31:0] a;
		logic [31:0] b;
		rd(`OFS_CNT0, a);
		repeat (10) @(posedge aclk);
		rd(`OFS_CNT0, b);
		chk(b, a);
	endtask
	// ==========================================
	// main sequence
	initial
	begin
		logic [31:0] v;
		aresetn = 1'b0;
		awaddr = 8'h00;
		awvalid = 1'b0;
		wdata = 32'h0;
		wstrb = 4'hF;
		wvalid = 1'b0;
		bready = 1'b0;
		araddr = 8'h00;
		arvalid = 1'b0;
		rready = 1'b0;
		direction_pin = 1'b0;
		emu_suspend = 1'b0;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		// reset values, unmapped place, count register
		rd(`OFS_CTL0, v);
		chk(v, 32'h0);
		rd(8'h3C, v);
		chk({30'h0, rsp}, {30'h0, `RESP_SLVERR});
		wr(8'h3C, 32'h1);
		chk({30'h0, rsp}, {30'h0, `RESP_SLVERR});
		wr(`OFS_CNT0, 32'h1234);
		rd(`OFS_CNT0, v);
		chk(v, 32'h1234);
		// up mode with every converter trigger
		wr(`OFS_PER0, 32'h3);
		wr(`OFS_CMP0, 32'h1);
		wr(`OFS_CNT0, 32'h0);
		wr(`OFS_CTL0, 32'h1142);
		for (int s = 1; s < 4; s++)
		begin
			wr(`OFS_SHARED, 32'(s));
			gap(1'b0, 32'h8);
		end
		rd(`OFS_SHARED, v);
		chk(v[13], 1'b1);
		rd(`OFS_FLAGS, v);
		chk(v[7:0], 8'h0E);
		chk(irq_master, 1'b0);
		wr(`OFS_MASK, 32'h2);
		chk(irq_master, 1'b1);
		wr(`OFS_CTL0, 32'h1102);
		frozen();
		wr(`OFS_FLAGS, 32'hFF);
		rd(`OFS_FLAGS, v);
		chk(v[7:0], 8'h00);
		chk(irq_master, 1'b0);
		wr(`OFS_CTL0, 32'h0040);
		frozen();
		// start above the period
		wr(`OFS_CNT0, 32'hFFFD);
		wr(`OFS_CTL0, 32'h1040);
		repeat (20) @(posedge aclk);
		wr(`OFS_CTL0, 32'h1000);
		rd(`OFS_FLAGS, v);
		chk(v[0], 1'b1);
		rd(`OFS_CNT0, v);
		chk(v <= 32'h3, 1'b1);
		// directional mode, down then up
		wr(`OFS_SHARED, 32'h1);
		wr(`OFS_CNT0, 32'h9);
		wr(`OFS_CTL0, 32'h1840);
		gap(1'b0, 32'h4);
		rd(`OFS_SHARED, v);
		chk(v[13], 1'b0);
		direction_pin <= 1'b1;
		gap(1'b0, 32'h4);
		rd(`OFS_SHARED, v);
		chk(v[13], 1'b1);
		// synchronized pair on the master period
		wr(`OFS_CTL0, 32'h1000);
		wr(`OFS_CNT0, 32'h0);
		wr(`OFS_PER1, 32'h7);
		wr(`OFS_CNT1, 32'h0);
		wr(`OFS_CTL1, 32'h1081);
		wr(`OFS_SHARED, 32'hA);
		wr(`OFS_CTL0, 32'h1040);
		do @(posedge aclk); while (adc_start_master !== 1'b1);
		chk(adc_start_slave, 1'b1);
		gap(1'b1, 32'h4);
		// pin and decoder tick sources
		wr(`OFS_CTL1, 32'h0);
		wr(`OFS_CTL0, 32'h1050);
		gap(1'b0, 32'h20);
		wr(`OFS_CTL1, 32'h1870);
		gap(1'b1, 32'h20);
		// emulation suspend
		wr(`OFS_CTL0, 32'h1040);
		emu_suspend <= 1'b1;
		frozen();
		wr(`OFS_CTL0, 32'h9040);
		gap(1'b0, 32'h4);
		wr(`OFS_CTL0, 32'h5040);
		repeat (20) @(posedge aclk);
		rd(`OFS_CNT0, v);
		chk(v, 32'h0);
		emu_suspend <= 1'b0;
		// continuous up/down: period event every two times the period
		wr(`OFS_CTL0, 32'h0840);
		gap(1'b0, 32'h6);
		// slave request follows its mask
		chk(irq_slave, 1'b0);
		wr(`OFS_MASK, 32'h80);
		chk(irq_slave, 1'b1);
		tally_and_finish();
	end
endmodule // gp_timer_pair_counter_tb

// ===== gp_timer_pkg.sv
package gp_timer_pkg;
	typedef enum logic [1:0] {mode_stop, mode_updown, mode_up, mode_dir} mode_t;
	typedef enum logic [1:0] {src_int, src_ext, src_rsvd, src_quad} clk_src_t;
	typedef enum logic [1:0] {emu_halt_now, emu_halt_end, emu_run, emu_run_alt} emu_t;
	typedef enum logic [1:0] {rl_zero, rl_zero_per, rl_imm, rl_imm_alt} reload_t;
	typedef enum logic [1:0] {soc_none, soc_udf, soc_per, soc_cmp} soc_t;
endpackage
